//--- logic/sec_err_pkg.sv
package sec_err_pkg;

	// Configuration space byte offsets
	localparam logic [11:0] SEVERITY_OFFSET = 12'h134;
	localparam logic [11:0] CAPS_CONTROL_OFFSET = 12'h138;

	// Severity register layout and value after fundamental reset
	localparam logic [31:0] SEVERITY_RESET = 32'h0000_1340;
	localparam logic [31:0] SEVERITY_WRITABLE = 32'h0000_3FEE;
	localparam logic [31:0] SEVERITY_REPORTING = 32'h0000_1E8C;
	localparam logic [31:0] SEVERITY_PCIX_ONLY = 32'h0000_2162;

	// Bit positions of the severity fields
	localparam int SYSTEM_ERR_SEEN_BIT = 12;
	localparam int PARITY_ERR_SEEN_BIT = 11;
	localparam int DELAYED_TXN_EXPIRY_BIT = 10;
	localparam int BAD_ADDRESS_BIT = 9;
	localparam int BAD_DATA_BIT = 7;
	localparam int INITIATOR_ABORT_BIT = 3;
	localparam int RESPONDER_ABORT_BIT = 2;
	// Positions of the inert PCI-X severity fields
	localparam int INTERNAL_FAULT_BIT = 13;
	localparam int ATTRIBUTE_FAULT_BIT = 8;
	localparam int SPLIT_MSG_DATA_BIT = 6;
	localparam int UNEXPECTED_SPLIT_BIT = 5;
	localparam int SPLIT_INITIATOR_ABORT_BIT = 1;

	// Capabilities and control register layout
	localparam int POINTER_WIDTH = 5;
	localparam logic [4:0] POINTER_RESET = 5'h00;

	// Bus answer latency, in clock cycles
	localparam int ACK_LATENCY_CYCLES = 1;

endpackage

//--- logic/lowest_bit_index.sv
`timescale 1ns/1ns

// Returns the position of the lowest set bit of a vector
module lowest_bit_index #(
	parameter int WIDTH = 32,
	parameter int INDEX_WIDTH = 5
) (
	// Candidate vector
	input wire logic [WIDTH-1:0] bits_in,
	// Result
	output logic found,
	output logic [INDEX_WIDTH-1:0] index
);

	// Scan from the top down so the lowest set bit wins
	always_comb begin
		found = 1'b0;
		index = '0;
		for (int i = WIDTH - 1; i >= 0; i--) begin
			if (bits_in[i]) begin
				found = 1'b1;
				index = INDEX_WIDTH'(i);
			end
		end
	end

endmodule

//--- logic/secondary_error_severity_regs.sv
`timescale 1ns/1ns

// Summary of operation
// (R1) Report fatal when severity set, else nonfatal
// (R2) Bits 12 and 9 reset to fatal
// (R3) Bits 11,10,7,3,2 reset to nonfatal
// (R4) PCI-X-only severity bits are inert storage
// (R5) Severity reserved bits ignore writes, read zero
// (R6) Caps register read-only, upper bits zero
// (R7) Pointer loads status position of first error
// (R8) Sticky state cleared only by fundamental reset
// (R9) Masked errors never report nor move pointer
// (R10) Pointer loads only with no error pending
module secondary_error_severity_regs
	import sec_err_pkg::*;
(
	// Clock, reset and enable
	input wire logic clk,
	input wire logic reset,
	input wire logic clk_en,
	// Fundamental reset sources, active low
	input wire logic pcie_reset_n,
	input wire logic global_reset_input_n,
	// Configuration space access
	input wire logic cfg_req,
	input wire logic cfg_write,
	input wire logic [11:0] cfg_addr,
	input wire logic [3:0] cfg_byte_en,
	input wire logic [31:0] cfg_wdata,
	output logic cfg_ack,
	output logic [31:0] cfg_rdata,
	// Error events and state of the status and mask registers
	input wire logic [31:0] err_detect,
	input wire logic [31:0] err_mask,
	input wire logic err_pending,
	// Error message requests toward the upstream port
	output logic err_fatal_msg,
	output logic err_nonfatal_msg,
	// Current severity setting and pointer, for the rest of the bridge
	output logic [31:0] severity_value,
	output logic [POINTER_WIDTH-1:0] oldest_fault_pointer
);

	// Fundamental reset: either source asserted
	logic fundamental_reset;
	// Sticky storage
	logic [31:0] severity_r, severity_nxt;
	logic [POINTER_WIDTH-1:0] pointer_r, pointer_nxt;
	// Bus answer state
	logic ack_r, ack_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	// Message request pulses
	logic fatal_r, fatal_nxt;
	logic nonfatal_r, nonfatal_nxt;
	// Error qualification
	logic [31:0] live_errors;
	logic [31:0] byte_mask;
	logic first_found;
	logic [POINTER_WIDTH-1:0] first_index;
	// Named severity fields: one selects fatal, zero nonfatal
	logic internal_fault_level; // Inert, PCI-X class
	logic system_err_seen_level; // Fatal after reset
	logic parity_err_seen_level; // Nonfatal after reset
	logic delayed_txn_expiry_level; // Nonfatal after reset
	logic bad_address_level; // Fatal after reset
	logic attribute_fault_level; // Inert, PCI-X class
	logic bad_data_level; // Nonfatal after reset
	logic split_msg_data_level; // Inert, PCI-X class
	logic unexpected_split_level; // Inert, PCI-X class
	logic initiator_abort_level; // Nonfatal after reset
	logic responder_abort_level; // Nonfatal after reset
	logic split_initiator_abort_level; // Inert, PCI-X class
	// Word seen by software and the per-class reporting levels
	logic [31:0] severity_readback;
	logic [31:0] report_level;

	// Sampled on the clock like any input; acts even with the enable low
	assign fundamental_reset = ~pcie_reset_n | ~global_reset_input_n; // [R8]

	// Split the severity word into its named fields
	always_comb begin
		internal_fault_level = severity_r[INTERNAL_FAULT_BIT]; // [R4]
		system_err_seen_level = severity_r[SYSTEM_ERR_SEEN_BIT];
		parity_err_seen_level = severity_r[PARITY_ERR_SEEN_BIT];
		delayed_txn_expiry_level = severity_r[DELAYED_TXN_EXPIRY_BIT];
		bad_address_level = severity_r[BAD_ADDRESS_BIT];
		attribute_fault_level = severity_r[ATTRIBUTE_FAULT_BIT]; // [R4]
		bad_data_level = severity_r[BAD_DATA_BIT];
		split_msg_data_level = severity_r[SPLIT_MSG_DATA_BIT]; // [R4]
		unexpected_split_level = severity_r[UNEXPECTED_SPLIT_BIT]; // [R4]
		initiator_abort_level = severity_r[INITIATOR_ABORT_BIT];
		responder_abort_level = severity_r[RESPONDER_ABORT_BIT];
		split_initiator_abort_level = severity_r[SPLIT_INITIATOR_ABORT_BIT]; // [R4]
	end

	// Read-back word rebuilt field by field; reserved positions stay zero
	always_comb begin
		severity_readback = 32'h0000_0000; // [R5]
		severity_readback[INTERNAL_FAULT_BIT] = internal_fault_level;
		severity_readback[SYSTEM_ERR_SEEN_BIT] = system_err_seen_level;
		severity_readback[PARITY_ERR_SEEN_BIT] = parity_err_seen_level;
		severity_readback[DELAYED_TXN_EXPIRY_BIT] = delayed_txn_expiry_level;
		severity_readback[BAD_ADDRESS_BIT] = bad_address_level;
		severity_readback[ATTRIBUTE_FAULT_BIT] = attribute_fault_level;
		severity_readback[BAD_DATA_BIT] = bad_data_level;
		severity_readback[SPLIT_MSG_DATA_BIT] = split_msg_data_level;
		severity_readback[UNEXPECTED_SPLIT_BIT] = unexpected_split_level;
		severity_readback[INITIATOR_ABORT_BIT] = initiator_abort_level;
		severity_readback[RESPONDER_ABORT_BIT] = responder_abort_level;
		severity_readback[SPLIT_INITIATOR_ABORT_BIT] = split_initiator_abort_level;
	end

	// Only classes the bridge can raise carry a level; PCI-X ones never report
	always_comb begin
		report_level = 32'h0000_0000; // [R4]
		report_level[SYSTEM_ERR_SEEN_BIT] = system_err_seen_level;
		report_level[PARITY_ERR_SEEN_BIT] = parity_err_seen_level;
		report_level[DELAYED_TXN_EXPIRY_BIT] = delayed_txn_expiry_level;
		report_level[BAD_ADDRESS_BIT] = bad_address_level;
		report_level[BAD_DATA_BIT] = bad_data_level;
		report_level[INITIATOR_ABORT_BIT] = initiator_abort_level;
		report_level[RESPONDER_ABORT_BIT] = responder_abort_level;
	end

	// Status, mask and header log sit outside; they meet this block through
	// err_detect, err_mask and err_pending, so masking is applied here again
	// Only unmasked errors that the bridge can really raise take part
	assign live_errors = err_detect & ~err_mask & SEVERITY_REPORTING; // [R9] [R4]

	// Expand byte enables into a bit mask
	// Reads ignore the byte enables; only writes use the mask
	always_comb begin
		for (int b = 0; b < 4; b++) begin
			byte_mask[b*8 +: 8] = {8{cfg_byte_en[b]}};
		end
	end

	// Picks the position for the pointer among simultaneous errors
	// Fixed priority keeps the choice repeatable when errors coincide
	lowest_bit_index #(
		.WIDTH(32),
		.INDEX_WIDTH(POINTER_WIDTH)
	) u_first (
		.bits_in(live_errors),
		.found(first_found),
		.index(first_index)
	);

	// Next values of the sticky severity and pointer state
	always_comb begin
		severity_nxt = severity_r;
		pointer_nxt = pointer_r;
		// Writes reach only implemented bits; reserved bits stay zero
		// Byte lanes pick which parts of the word change
		if (cfg_req && cfg_write && cfg_addr == SEVERITY_OFFSET) begin
			severity_nxt = (severity_r & ~(byte_mask & SEVERITY_WRITABLE))
				| (cfg_wdata & byte_mask & SEVERITY_WRITABLE); // [R5] [R4]
		end
		// Keep the oldest error while the status still holds one
		if (first_found && !err_pending) begin // [R10]
			// Coinciding new errors: the lowest position is taken
			pointer_nxt = first_index; // [R7]
		end
	end

	// Sticky state: fundamental reset only, frozen while disabled
	always_ff @(posedge clk) begin
		if (fundamental_reset) begin
			// Either source restores the defaults; the enable is not needed
			severity_r <= SEVERITY_RESET; // [R2] [R3] [R8]
			pointer_r <= POINTER_RESET; // [R8]
		end else if (clk_en) begin
			// Both advance only while the enable is high
			severity_r <= severity_nxt;
			pointer_r <= pointer_nxt;
		end
	end

	// Next values of the bus answer and the message requests
	always_comb begin
		// Every accepted request is answered on the next edge
		ack_nxt = cfg_req;
		// Read data holds until the next read is taken
		rdata_nxt = rdata_r;
		if (cfg_req && !cfg_write) begin
			unique case (cfg_addr)
				SEVERITY_OFFSET: rdata_nxt = severity_readback; // [R5]
				CAPS_CONTROL_OFFSET: rdata_nxt = {27'h0, pointer_r}; // [R6]
				// Unmapped offsets read as zero
				default: rdata_nxt = 32'h0000_0000;
			endcase
		end
		// A group of simultaneous errors may need both message kinds
		fatal_nxt = |(live_errors & report_level); // [R1]
		nonfatal_nxt = |(live_errors & ~report_level); // [R1]
	end

	// Registered requests cost a cycle but keep glitches off the ports
	// Non-sticky state follows the ordinary reset as well
	always_ff @(posedge clk) begin
		if (reset || fundamental_reset) begin
			// Drop any answer or request in flight
			ack_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			fatal_r <= 1'b0;
			nonfatal_r <= 1'b0;
		end else if (clk_en) begin
			// Frozen while the enable is low
			ack_r <= ack_nxt;
			rdata_r <= rdata_nxt;
			fatal_r <= fatal_nxt;
			nonfatal_r <= nonfatal_nxt;
		end
	end

	// Outputs straight from flip-flops
	// Nothing combinational reaches these ports
	assign cfg_ack = ack_r;
	assign cfg_rdata = rdata_r;
	assign err_fatal_msg = fatal_r;
	assign err_nonfatal_msg = nonfatal_r;
	assign severity_value = severity_r;
	assign oldest_fault_pointer = pointer_r;

endmodule

//--- dv/sec_err_props.sv
`timescale 1ns/1ns
// Port-level checks on severity storage, pointer and messages
module sec_err_props
	import sec_err_pkg::*;
(
	// Clock, enable and resets
	input wire logic clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic pcie_reset_n,
	input wire logic global_reset_input_n,
	// Config bus
	input wire logic cfg_req,
	input wire logic cfg_write,
	input wire logic [11:0] cfg_addr,
	input wire logic cfg_ack,
	input wire logic [31:0] cfg_rdata,
	// Errors and state
	input wire logic [31:0] err_detect,
	input wire logic [31:0] err_mask,
	input wire logic err_pending,
	input wire logic err_fatal_msg,
	input wire logic err_nonfatal_msg,
	input wire logic [31:0] severity_value,
	input wire logic [POINTER_WIDTH-1:0] oldest_fault_pointer
);
	// Fundamental reset; errors able to report
	wire logic fund_reset = !pcie_reset_n || !global_reset_input_n;
	wire logic [31:0] live = err_detect & ~err_mask & SEVERITY_REPORTING;
	default clocking @(posedge clk); endclocking
	default disable iff (reset || fund_reset);
	fatal_req_a: assert property (clk_en && |(live & severity_value) |=> err_fatal_msg) else $error("fatal");
	nonfatal_req_a: assert property (clk_en && |(live & ~severity_value) |=> err_nonfatal_msg) else $error("nf");
	quiet_msg_a: assert property (clk_en && !(|live) |=> !err_fatal_msg && !err_nonfatal_msg) else $error("msg");
	reserved_zero_a: assert property ((severity_value & ~SEVERITY_WRITABLE) == 0) else $error("rsvd");
	caps_read_a: assert property (clk_en && cfg_req && !cfg_write && cfg_addr == CAPS_CONTROL_OFFSET
		|=> cfg_rdata == {27'h0, $past(oldest_fault_pointer)}) else $error("caps");
	reset_clear_a: assert property (disable iff (1'b0) fund_reset
		|=> severity_value == SEVERITY_RESET && oldest_fault_pointer == POINTER_RESET) else $error("reset value");
	sticky_hold_a: assert property (disable iff (fund_reset) reset && !cfg_req
		|=> $stable(severity_value)) else $error("st");
	ptr_load_a: assert property (clk_en && !err_pending && $onehot(live)
		|=> (32'h1 << oldest_fault_pointer) == $past(live)) else $error("ptr");
	ptr_hold_a: assert property (clk_en && (err_pending || !(|live)) |=> $stable(oldest_fault_pointer)) else $error("h");
	freeze_hold_a: assert property (!clk_en |=> $stable(severity_value) && $stable(oldest_fault_pointer)
		&& $stable(cfg_ack) && $stable(err_fatal_msg)) else $error("enable freeze");
	ack_follow_a: assert property (clk_en && cfg_req |=> cfg_ack) else $error("ack");
	cover property (err_fatal_msg && err_nonfatal_msg);
	cover property (cfg_req && cfg_write);
	cover property (err_pending && |live);
	cover property (!clk_en && cfg_req);
endmodule
bind secondary_error_severity_regs sec_err_props props (
	.clk(clk),
	.reset(reset),
	.clk_en(clk_en),
	.pcie_reset_n(pcie_reset_n),
	.global_reset_input_n(global_reset_input_n),
	.cfg_req(cfg_req),
	.cfg_write(cfg_write),
	.cfg_addr(cfg_addr),
	.cfg_ack(cfg_ack),
	.cfg_rdata(cfg_rdata),
	.err_detect(err_detect),
	.err_mask(err_mask),
	.err_pending(err_pending),
	.err_fatal_msg(err_fatal_msg),
	.err_nonfatal_msg(err_nonfatal_msg),
	.severity_value(severity_value),
	.oldest_fault_pointer(oldest_fault_pointer)
);

//--- dv/rc_model.sv
`timescale 1ns/1ns
// Upstream receiver tallying error messages
module rc_model (
	// Clock
	input wire logic clk,
	// Message requests from the bridge
	input wire logic fatal,
	input wire logic nonfatal,
	// Running tallies
	output int fatal_count,
	output int nonfatal_count
);
	initial {fatal_count, nonfatal_count} = 0;
	// Unknown before reset must not poison the tally
	always @(posedge clk) begin
		fatal_count <= fatal_count + (fatal === 1'b1);
		nonfatal_count <= nonfatal_count + (nonfatal === 1'b1);
	end
endmodule

//--- dv/secondary_error_severity_regs_tb.sv
`timescale 1ns/1ns
module secondary_error_severity_regs_tb;
	import sec_err_pkg::*;
	logic clk = 0, reset = 1, ce = 1, pr_n = 0, gr_n = 1, req = 0, wr = 0, pend = 0, ack, fm, nm;
	logic [11:0] addr = 0;
	logic [3:0] be = 0;
	logic [31:0] wd = 0, det = 0, msk = 0, rd, sev;
	logic [4:0] ptr;
	int fails = 0, num_checks = 0, seed = 32'h48a0e634, cyc = 0, nf, nn;
	int pos[7] = '{12, 11, 10, 9, 7, 3, 2};
	secondary_error_severity_regs uut (.clk(clk), .reset(reset), .clk_en(ce), .pcie_reset_n(pr_n),
		.global_reset_input_n(gr_n), .cfg_req(req), .cfg_write(wr), .cfg_addr(addr), .cfg_byte_en(be),
		.cfg_wdata(wd), .cfg_ack(ack), .cfg_rdata(rd), .err_detect(det), .err_mask(msk), .err_pending(pend),
		.err_fatal_msg(fm), .err_nonfatal_msg(nm), .severity_value(sev), .oldest_fault_pointer(ptr));
	rc_model rc (.clk(clk), .fatal(fm), .nonfatal(nm), .fatal_count(nf), .nonfatal_count(nn));
	initial forever #5 clk = ~clk;
	// Hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			fails++;
			end_sim;
		end
	end
	task chk(input logic [31:0] s, input logic [31:0] x);
		num_checks++;
		if (s !== x) begin
			fails++;
			$display("FAIL %0t seen %h expected %h", $time, s, x);
		end
	endtask
	// One access, request held for one edge
	task acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] b);
		@(negedge clk) {req, wr, addr, wd, be} = {1'b1, w, a, d, b};
		@(negedge clk) req = 0;
		chk(ack, 1);
	endtask
	task rd_chk(input logic [11:0] a, input logic [31:0] x);
		acc(0, a, 0, 0);
		chk(rd, x);
	endtask
	task ev(input logic [31:0] d, m, input logic p);
		@(negedge clk) {det, msk, pend} = {d, m, p};
		@(negedge clk) det = 0;
	endtask
	// Byte-merged write, only storage bits kept
	function logic [31:0] wexp(input logic [31:0] o, d, input logic [3:0] b);
		logic [31:0] k;
		k = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
		return ((o & ~k) | (d & k)) & SEVERITY_WRITABLE;
	endfunction
	task end_sim;
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		logic [31:0] e, d;
		logic [3:0] b;
		repeat (20) @(negedge clk);
		{reset, pr_n} = 2'b01;
		rd_chk(12'h134, 32'h1340);
		e = 32'h1340;
		// First pass all ones, then random
		for (int i = 0; i < 6; i++) begin
			d = i ? $random(seed) : 32'hFFFF_FFFF;
			b = i ? 4'($random(seed)) : 4'hF;
			acc(1, 12'h134, d, b);
			e = wexp(e, d, b);
			rd_chk(12'h134, e);
		end
		acc(1, 12'h138, 32'hFFFF_FFFF, 4'hF);
		rd_chk(12'h138, 0);
		rd_chk(12'h13C, 0);
		acc(1, 12'h134, 32'h2B66, 4'hF);
		e = 32'h2B66;
		foreach (pos[i]) begin
			ev(32'h1 << pos[i], 0, 0);
			chk({fm, nm, ptr}, {e[pos[i]], !e[pos[i]], 5'(pos[i])});
		end
		ev(32'h808, 0, 0);
		chk({fm, nm, ptr}, 7'h63);
		ev(32'h400, 0, 1);
		chk({nm, ptr}, 6'h23);
		ev(32'h2962, 32'h800, 0);
		chk({fm, nm, ptr}, 7'h03);
		// Enable low: a write and an error must leave all state alone
		@(negedge clk) {ce, req, wr, addr, wd, be, det} = {1'b0, 1'b1, 1'b1, 12'h134, 32'h0, 4'hF, 32'h1000};
		@(negedge clk) {req, det} = 33'h0;
		chk({ack, fm, nm}, 3'h0);
		@(negedge clk) ce = 1;
		chk(sev, 32'h2B66);
		chk(ptr, 3);
		@(negedge clk) reset = 1;
		@(negedge clk) reset = 0;
		chk(sev, 32'h2B66);
		chk(ptr, 3);
		@(negedge clk) gr_n = 0;
		@(negedge clk) gr_n = 1;
		chk(sev, 32'h1340);
		chk(ptr, 0);
		chk(nf, 4);
		chk(nn, 6);
		// Let the reset assertion finish its next-cycle check
		repeat (2) @(negedge clk);
		end_sim;
	end
endmodule
